// ### chan_cfg_pkg.sv
// Constants and types for the channel 2/3 configuration register bank
// Overview of operation
// - Channel 2 analog gain is a six-bit field in bits 7 to 2, codes 0 to 42 give 0 to 42 dB, codes 43 to 63 are reserved.
// - A digital volume code of zero mutes the channel so its output samples are silenced.
// - Volume codes 1 to 255 step 0.5 dB from -100 dB, code 201 is 0 dB and code 255 is 27 dB.
// - The channel 2 volume register resets to C9 hex, unity volume.
// - The four-bit gain trim in bits 7 to 4 runs from -0.8 dB at code 0 in 0.1 dB steps, code 8 is 0 dB, code 15 is 0.7 dB.
// - The channel 2 gain trim register resets to 80 hex, the 0 dB trim.
// - The eight-bit phase trim delays the channel by that many modulator clock cycles, zero meaning none.
// - Channel 3 input bit 7 picks microphone input when 0 and line input when 1.
// - Channel 3 source field in bits 6 to 5 picks analog differential, analog single-ended, digital microphone, or reserved.
// - Channel 3 bit 4 picks AC coupling at 0 and DC coupling at 1, and only matters for analog sources.
// - Channel 3 impedance in bits 3 to 2 picks about 2.5, 10 or 20 kilohms for analog input, code 3 reserved.
// - Channel 3 bit 0 enables automatic gain, which then runs as bit 3 of the global auto gain register sets.
// - The channel 2 analog gain register lives at address 42 hex of page 0.
package chan_cfg_pkg;
  localparam logic [7:0] PAGE_ZERO       = 8'h00;
  localparam logic [7:0] ADDR_CHAN2_ANALOG_GAIN   = 8'h42;
  localparam logic [7:0] ADDR_CH2_VOLUME = 8'h43;
  localparam logic [7:0] ADDR_CH2_TRIM   = 8'h44;
  localparam logic [7:0] ADDR_CH2_PHASE  = 8'h45;
  localparam logic [7:0] ADDR_CH3_INPUT  = 8'h46;

  localparam logic [7:0] RST_CHAN2_ANALOG_GAIN    = 8'h00;
  localparam logic [7:0] RST_CH2_VOLUME  = 8'hC9;
  localparam logic [7:0] RST_CH2_TRIM    = 8'h80;
  localparam logic [7:0] RST_CH2_PHASE   = 8'h00;
  localparam logic [7:0] RST_CH3_INPUT   = 8'h00;

  // Writable bit masks; zero bits are reserved
  localparam logic [7:0] MASK_CHAN2_ANALOG_GAIN   = 8'hFC;
  localparam logic [7:0] MASK_CH2_TRIM   = 8'hF0;
  localparam logic [7:0] MASK_CH3_INPUT  = 8'hFD;
  localparam logic [7:0] MASK_FULL       = 8'hFF;

  localparam logic [5:0] GAIN_MAX_CODE   = 6'h2A;
  localparam logic [7:0] VOLUME_MUTE     = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  localparam int         GLOBAL_AGC_BIT  = 3;

  typedef enum logic [1:0] {
    SRC_ANALOG_DIFF,
    SRC_ANALOG_SINGLE,
    SRC_PULSE_DENSITY,
    SRC_RESERVED
  } input_source_type;

  typedef enum logic [1:0] {
    IMP_2K5,
    IMP_10K,
    IMP_20K,
    IMP_RESERVED
  } impedance_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic [5:0]       chan2_analog_gain;
    logic [7:0]       chan2_digital_volume;
    logic [3:0]       chan2_gain_trim;
    logic [7:0]       chan2_phase_trim;
    logic             chan3_input_kind;
    input_source_type chan3_input_source;
    logic             chan3_coupling_select;
    impedance_type    chan3_input_impedance;
    logic             chan3_auto_gain_enable;
  } chan_cfg_type;
endpackage

// ### chan_mute_stage.sv
// Output sample stage that silences the channel at volume code zero
module chan_mute_stage #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk,         // System clock
  input  wire logic                resetn,      // Sync reset, active low
  input  wire logic [7:0]          volume,      // Digital volume code
  input  wire logic [SAMPLE_W-1:0] sample_in,   // Sample from datapath
  output logic      [SAMPLE_W-1:0] sample_out   // Muted or passed sample
);
  import chan_cfg_pkg::*;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sample_out <= '0;
    end else if (volume == VOLUME_MUTE) begin
      sample_out <= '0;
    end else begin
      sample_out <= sample_in;
    end
  end

  property p_mute_silences;
    @(posedge clk) disable iff (!resetn)
    (volume == VOLUME_MUTE) |=> (sample_out == '0);
  endproperty
  a_mute_silences: assert property (p_mute_silences) else $error("muted sample not zero");

  property p_pass_through;
    @(posedge clk) disable iff (!resetn)
    (volume != VOLUME_MUTE) |=> (sample_out == $past(sample_in));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("sample not passed");
endmodule // chan_mute_stage

// ### chan_cfg_regs.sv
// Channel 2 and 3 configuration registers on the control port
module chan_cfg_regs #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                      clk,              // Control port clock
  input  wire logic                      resetn,           // Sync reset, active low
  input  wire chan_cfg_pkg::host_req_type req,             // Control port request
  output logic      [7:0]                rdata,            // Read data
  output logic                           rvalid,           // Read data valid
  input  wire logic [7:0]                global_auto_gain_cfg, // Global AGC register
  input  wire logic [SAMPLE_W-1:0]       chan2_sample_in,  // Channel 2 samples
  output logic      [SAMPLE_W-1:0]       chan2_sample_out, // Volume-muted samples
  output chan_cfg_pkg::chan_cfg_type     cfg,              // Decoded fields
  output logic                           chan2_gain_reserved, // Gain code 43..63
  output logic                           chan3_analog_sel, // Analog source active
  output logic                           chan3_pdm_sel,    // Digital mic source
  output logic                           chan3_agc_active, // AGC running
  output logic                           chan3_agc_mode    // Global AGC mode bit
);
  import chan_cfg_pkg::*;

  logic [7:0] gain_q;
  logic [7:0] volume_q;
  logic [7:0] trim_q;
  logic [7:0] phase_q;
  logic [7:0] input_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;

  function automatic logic hit(input host_req_type r, input logic [7:0] a);
    hit = (r.page == PAGE_ZERO) && (r.addr == a);
  endfunction

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gain_q <= RST_CHAN2_ANALOG_GAIN;
    end else if (req.wr && hit(req, ADDR_CHAN2_ANALOG_GAIN)) begin
      gain_q <= req.wdata & MASK_CHAN2_ANALOG_GAIN;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      volume_q <= RST_CH2_VOLUME;
    end else if (req.wr && hit(req, ADDR_CH2_VOLUME)) begin
      volume_q <= req.wdata & MASK_FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      trim_q <= RST_CH2_TRIM;
    end else if (req.wr && hit(req, ADDR_CH2_TRIM)) begin
      trim_q <= req.wdata & MASK_CH2_TRIM;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= RST_CH2_PHASE;
    end else if (req.wr && hit(req, ADDR_CH2_PHASE)) begin
      phase_q <= req.wdata & MASK_FULL;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      input_q <= RST_CH3_INPUT;
    end else if (req.wr && hit(req, ADDR_CH3_INPUT)) begin
      input_q <= req.wdata & MASK_CH3_INPUT;
    end
  end

  always_comb begin
    rdata_d = READ_ZERO;
    if (hit(req, ADDR_CHAN2_ANALOG_GAIN)) begin
      rdata_d = gain_q;
    end else if (hit(req, ADDR_CH2_VOLUME)) begin
      rdata_d = volume_q;
    end else if (hit(req, ADDR_CH2_TRIM)) begin
      rdata_d = trim_q;
    end else if (hit(req, ADDR_CH2_PHASE)) begin
      rdata_d = phase_q;
    end else if (hit(req, ADDR_CH3_INPUT)) begin
      rdata_d = input_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q  <= READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign rdata  = rdata_q;
  assign rvalid = rvalid_q;

  assign cfg.chan2_analog_gain      = gain_q[7:2];
  assign cfg.chan2_digital_volume   = volume_q;
  assign cfg.chan2_gain_trim        = trim_q[7:4];
  assign cfg.chan2_phase_trim       = phase_q;
  assign cfg.chan3_input_kind       = input_q[7];
  assign cfg.chan3_input_source     = input_source_type'(input_q[6:5]);
  assign cfg.chan3_coupling_select  = input_q[4];
  assign cfg.chan3_input_impedance  = impedance_type'(input_q[3:2]);
  assign cfg.chan3_auto_gain_enable = input_q[0];

  assign chan2_gain_reserved = (gain_q[7:2] > GAIN_MAX_CODE);

  // Coupling and impedance matter only when this is set
  assign chan3_analog_sel = (cfg.chan3_input_source == SRC_ANALOG_DIFF) ||
                            (cfg.chan3_input_source == SRC_ANALOG_SINGLE);
  assign chan3_pdm_sel    = (cfg.chan3_input_source == SRC_PULSE_DENSITY);

  assign chan3_agc_active = input_q[0];
  assign chan3_agc_mode   = input_q[0] & global_auto_gain_cfg[GLOBAL_AGC_BIT];

  chan_mute_stage #(
    .SAMPLE_W (SAMPLE_W)
  ) u_mute (
    .clk        (clk),
    .resetn     (resetn),
    .volume     (volume_q),
    .sample_in  (chan2_sample_in),
    .sample_out (chan2_sample_out)
  );

  property p_volume_reset;
    @(posedge clk) $past(!resetn) |-> (volume_q == RST_CH2_VOLUME);
  endproperty
  a_volume_reset: assert property (p_volume_reset) else $error("volume reset wrong");

  property p_trim_reset;
    @(posedge clk) $past(!resetn) |-> (cfg.chan2_gain_trim == RST_CH2_TRIM[7:4]);
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim reset wrong");

  property p_gain_reserved;
    @(posedge clk) disable iff (!resetn)
    chan2_gain_reserved == (cfg.chan2_analog_gain >= (GAIN_MAX_CODE + 6'h01));
  endproperty
  a_gain_reserved: assert property (p_gain_reserved) else $error("gain reserve flag wrong");

  property p_reserved_zero;
    @(posedge clk) disable iff (!resetn)
    (req.rd && hit(req, ADDR_CHAN2_ANALOG_GAIN)) |=> (rdata[1:0] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_readback;
    @(posedge clk) disable iff (!resetn)
    (req.wr && hit(req, ADDR_CH2_PHASE)) ##1 !req.wr ##1
      (req.rd && hit(req, ADDR_CH2_PHASE) && !req.wr) |=> (rdata == $past(req.wdata, 3));
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    !(req.wr && hit(req, ADDR_CH2_VOLUME)) |=> $stable(volume_q);
  endproperty
  a_hold: assert property (p_hold) else $error("volume changed without write");

  property p_agc_mode;
    @(posedge clk) disable iff (!resetn)
    chan3_agc_mode == (input_q[0] && global_auto_gain_cfg[GLOBAL_AGC_BIT]);
  endproperty
  a_agc_mode: assert property (p_agc_mode) else $error("agc mode wrong");

  property p_pdm_sel;
    @(posedge clk) disable iff (!resetn)
    (req.wr && hit(req, ADDR_CH3_INPUT) && (req.wdata[6:5] == 2'b10)) |=>
      (chan3_pdm_sel && !chan3_analog_sel);
  endproperty
  a_pdm_sel: assert property (p_pdm_sel) else $error("pdm select wrong");

  property p_unmapped_zero;
    @(posedge clk) disable iff (!resetn)
    (req.rd && (req.page != PAGE_ZERO)) |=> (rdata == READ_ZERO);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_gain_masked;
    @(posedge clk) disable iff (!resetn)
    (req.wr && hit(req, ADDR_CHAN2_ANALOG_GAIN)) |=> (gain_q == ($past(req.wdata) & MASK_CHAN2_ANALOG_GAIN));
  endproperty
  a_gain_masked: assert property (p_gain_masked) else $error("gain reserved bits kept");

  property p_trim_reserved;
    @(posedge clk) disable iff (!resetn)
    (req.rd && hit(req, ADDR_CH2_TRIM)) |=> (rdata[3:0] == 4'h0);
  endproperty
  a_trim_reserved: assert property (p_trim_reserved) else $error("trim low bits not zero");

  property p_input_reserved;
    @(posedge clk) disable iff (!resetn)
    (req.rd && hit(req, ADDR_CH3_INPUT)) |=> (rdata[1] == 1'b0);
  endproperty
  a_input_reserved: assert property (p_input_reserved) else $error("input bit 1 not zero");

  property p_rvalid_pulse;
    @(posedge clk) disable iff (!resetn)
    rvalid == $past(req.rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid misplaced");

  property p_analog_sel;
    @(posedge clk) disable iff (!resetn)
    (req.wr && hit(req, ADDR_CH3_INPUT) && !req.wdata[6]) |=>
      (chan3_analog_sel && !chan3_pdm_sel);
  endproperty
  a_analog_sel: assert property (p_analog_sel) else $error("analog select wrong");

  property p_phase_store;
    @(posedge clk) disable iff (!resetn)
    (req.wr && hit(req, ADDR_CH2_PHASE)) |=> (cfg.chan2_phase_trim == $past(req.wdata));
  endproperty
  a_phase_store: assert property (p_phase_store) else $error("phase trim not stored");
endmodule // chan_cfg_regs

// ### host_model.sv
// Host controller model that drives the control port of the bank
module host_model (
  input  wire logic                  clk,    // Control port clock
  input  wire logic [7:0]            rdata,  // Read data from the bank
  input  wire logic                  rvalid, // Read data valid
  output chan_cfg_pkg::host_req_type req     // Request to the bank
);
  timeunit 1ns;
  timeprecision 100ps;
  import chan_cfg_pkg::*;

  initial req = '0;

  // Each access is one strobe cycle, then one idle edge before the next
  task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, page: page, addr: addr, wdata: data};
    @(posedge clk);
    #1;
    req = '0;
  endtask

  // Read data and valid are taken 1 ns after the edge that samples the strobe
  task automatic rd(input logic [7:0] page, input logic [7:0] addr,
                    output logic [7:0] data, output logic valid);
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, page: page, addr: addr, wdata: 8'h00};
    @(posedge clk);
    #1;
    data = rdata;
    valid = rvalid;
    req = '0;
  endtask
endmodule // host_model

// ### tb.sv
// Self-checking bench for the channel 2/3 configuration bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import chan_cfg_pkg::*;

  logic         clk;
  logic         resetn;
  host_req_type req;
  logic [7:0]   rdata;
  logic [7:0]   gcfg;
  logic [7:0]   got;
  logic         rvalid;
  logic         vld;
  logic         gres;
  logic         asel;
  logic         psel;
  logic         agc_act;
  logic         agc_mode;
  logic [23:0]  s_in;
  logic [23:0]  s_out;
  chan_cfg_type cfg;
  int           num_errors = 0;
  int           n_compared = 0;
  int           cycles = 0;
  logic [7:0]   addrs [5] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
  logic [7:0]   rst_v [5] = '{8'h00, 8'hC9, 8'h80, 8'h00, 8'h00};
  logic [7:0]   mask_v [5] = '{8'hFC, 8'hFF, 8'hF0, 8'hFF, 8'hFD};

  host_model u_host_model (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

  chan_cfg_regs #(.SAMPLE_W(24)) u_chan_cfg_regs (
    .clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .global_auto_gain_cfg(gcfg), .chan2_sample_in(s_in), .chan2_sample_out(s_out),
    .cfg(cfg), .chan2_gain_reserved(gres), .chan3_analog_sel(asel),
    .chan3_pdm_sel(psel), .chan3_agc_active(agc_act), .chan3_agc_mode(agc_mode)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Valid flag and data are compared together
  task automatic rd_chk(input logic [7:0] page, input logic [7:0] a, input logic [7:0] e);
    u_host_model.rd(page, a, got, vld);
    check({vld, got}, {1'b1, e});
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("Error at %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    resetn = 1'b0;
    gcfg = 8'h00;
    s_in = 24'h12_3456;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'h00, addrs[i], rst_v[i]); // reset values
    end
    // Ones then zeros expose stuck and reserved bits
    for (int i = 0; i < 5; i++) begin
      u_host_model.wr(8'h00, addrs[i], 8'hFF);
      rd_chk(8'h00, addrs[i], mask_v[i]); // masked readback
      u_host_model.wr(8'h00, addrs[i], 8'h00);
      rd_chk(8'h00, addrs[i], 8'h00); // zero readback
    end
    u_host_model.wr(8'h01, 8'h43, 8'h55);
    rd_chk(8'h00, 8'h43, 8'h00); // other page ignored
    rd_chk(8'h01, 8'h43, 8'h00); // other page reads zero
    rd_chk(8'h00, 8'h47, 8'h00); // unmapped address
    u_host_model.wr(8'h00, 8'h42, 8'hAF);
    check(gres, 1'b1); // code 43 reserved
    rd_chk(8'h00, 8'h42, 8'hAC); // code kept, low bits dropped
    u_host_model.wr(8'h00, 8'h42, 8'hA8);
    check(gres, 1'b0); // code 42 legal
    check(cfg.chan2_analog_gain, 6'd42); // field position
    // Mute shows one stage after the volume write lands
    repeat (2) @(posedge clk);
    #1;
    check(s_out, 24'h00_0000); // loop left volume at zero
    u_host_model.wr(8'h00, 8'h43, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check(s_out, 24'h00_0000); // muted output
    u_host_model.wr(8'h00, 8'h43, 8'hC9);
    repeat (2) @(posedge clk);
    #1;
    check(s_out, 24'h12_3456); // unity passes sample
    check(cfg.chan2_digital_volume, 8'hC9); // volume code exported
    u_host_model.wr(8'h00, 8'h45, 8'hFF);
    check(cfg.chan2_phase_trim, 8'hFF); // full delay code
    u_host_model.wr(8'h00, 8'h44, 8'h5A);
    check(cfg.chan2_gain_trim, 4'h5); // upper nibble field
    // pin sharing is the host's duty; this bank holds no pin mux
    for (int s = 0; s < 4; s++) begin
      u_host_model.wr(8'h00, 8'h46, {s[0], s[1:0], ~s[0], s[1:0], 1'b1, s[1]});
      gcfg = s[0] ? 8'h08 : 8'hF7;
      @(posedge clk);
      #1;
      check(cfg.chan3_input_kind, s[0]); // kind bit
      check(cfg.chan3_input_source, s[1:0]); // source field
      check({asel, psel}, {s < 2, s == 2}); // source decode
      check(cfg.chan3_coupling_select, !s[0]); // coupling bit
      check(cfg.chan3_input_impedance, s[1:0]); // impedance field
      check({agc_act, agc_mode}, {s[1], s[1] & s[0]}); // auto gain
      check(cfg.chan3_auto_gain_enable, s[1]); // enable field
    end
    // Reset mid-run restores the defaults
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    rd_chk(8'h00, 8'h43, 8'hC9); // volume default again
    rd_chk(8'h00, 8'h44, 8'h80); // trim default again
    end_sim();
  end
endmodule // tb
